// file: spi_bidir_consts.svh
`ifndef SPI_BIDIR_CONSTS_SVH
`define SPI_BIDIR_CONSTS_SVH
// Sys clock cycles per half period of the master serial clock
`define SCK_HALF_CYCLES 4
// Serial edges in one byte transfer
`define EDGES_PER_BYTE 16
// Reset values
`define DATA_RESET 8'h00
`define TEF_RESET 1'b1
`define TCF_RESET 1'b0
`define MODE_FAULT_FLAG_RESET 1'b0
`endif

// file: spi_bidir_pkg.sv
package spi_bidir_pkg;
  // Software-written first control register
  typedef struct packed {
    logic system_enable_bit;
    logic master_select;
    logic select_output_enable;
    logic mode_fault_detect_enable;
  } ctrl1_t;
  // Software-written second control register
  typedef struct packed {
    logic single_wire_select;
    logic shared_pin_output_enable;
    logic stop_in_wait_bit;
  } ctrl2_t;
  // Status register
  typedef struct packed {
    logic mode_fault_flag;
    logic transfer_complete_flag;
    logic transmit_empty_flag;
  } status_t;
  // One driven pin: value and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pin_drv_t;
  typedef enum logic [0:0] {
    M_IDLE = 1'b0,
    M_RUN = 1'b1
  } mstate_t;
endpackage : spi_bidir_pkg

// file: spi_bidir_fault_power.sv
`timescale 1ns/10ps
`include "spi_bidir_consts.svh"
module spi_bidir_fault_power #(
  parameter int SCK_HALF = `SCK_HALF_CYCLES
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Processor power state
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  // Control register writes
  input wire logic ctrl1_wr,
  input wire spi_bidir_pkg::ctrl1_t ctrl1_wdata,
  input wire logic ctrl2_wr,
  input wire spi_bidir_pkg::ctrl2_t ctrl2_wdata,
  // Status and data access
  input wire logic status_rd,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output spi_bidir_pkg::ctrl1_t ctrl1_q,
  output spi_bidir_pkg::ctrl2_t ctrl2_q,
  output spi_bidir_pkg::status_t status_q,
  output logic [7:0] data_rdata,
  output logic irq,
  // Serial clock pin, also the slave link clock
  input wire logic sck_in,
  output spi_bidir_pkg::pin_drv_t sck_pin,
  // Data pins
  input wire logic mosi_in,
  output spi_bidir_pkg::pin_drv_t mosi_pin,
  input wire logic miso_in,
  output spi_bidir_pkg::pin_drv_t miso_pin,
  // Slave select pin, active low
  input wire logic ss_n_in,
  output spi_bidir_pkg::pin_drv_t ss_n_pin
);
  if (SCK_HALF < 1 || SCK_HALF > 255) begin : g_bad_half
    $error("SCK_HALF out of range");
  end

  spi_bidir_pkg::ctrl1_t c1_reg;
  spi_bidir_pkg::ctrl2_t c2_reg;
  logic mode_fault_flag_reg, tcf_reg, tef_reg;
  logic mode_fault_flag_armed_reg, tcf_armed_reg, tef_armed_reg;
  logic [7:0] tx_data_reg, rx_data_reg;
  spi_bidir_pkg::mstate_t mstate_reg;
  logic [7:0] div_reg, msh_reg;
  logic [3:0] edge_reg;
  logic sck_reg, mbit_reg;
  logic ss_s1_reg, ss_s2_reg, mi_s1_reg, mi_s2_reg, mo_s1_reg, mo_s2_reg;
  logic dt_s1_reg, dt_s2_reg, dt_s3_reg;
  logic pend_reg, sleep_d_reg, quiet_reg;
  logic [7:0] pend_data_reg, ld_data_reg;
  logic ld_tgl_reg, ak_s1_reg, ak_s2_reg;
  // Link clock domain
  logic [2:0] scnt_reg;
  logic [6:0] srx_reg;
  logic [7:0] shold_reg, stx_reg;
  logic done_tgl_reg, ld_s1_reg, ld_s2_reg, ld_ack_reg;

  // Decoding
  wire enabled = c1_reg.system_enable_bit;
  wire is_master = c1_reg.master_select;
  wire single = c2_reg.single_wire_select;
  // Stop always sleeps, wait only with stop-in-wait set
  wire sleep = cpu_stop | (cpu_wait & c2_reg.stop_in_wait_bit);
  wire ss_auto = is_master & c1_reg.select_output_enable & c1_reg.mode_fault_detect_enable;
  wire detect = enabled & is_master & c1_reg.mode_fault_detect_enable & ~ss_auto;
  wire fault_set = detect & ~ss_s2_reg;
  wire m_running = mstate_reg == spi_bidir_pkg::M_RUN;
  wire m_start = enabled & is_master & ~sleep & ~m_running & ~tef_reg & ~fault_set;
  wire half_tick = m_running & ~sleep & (div_reg == 8'(SCK_HALF - 1));
  wire m_done = half_tick & (edge_reg == 4'(`EDGES_PER_BYTE - 1));
  wire m_in = single ? mo_s2_reg : mi_s2_reg;
  wire slave_din = single ? miso_in : mosi_in;
  wire s_done_evt = dt_s2_reg ^ dt_s3_reg;
  wire s_done = s_done_evt & enabled & ~is_master;
  wire slave_busy = enabled & ~is_master & ~ss_s2_reg;
  // a sleep that starts and ends idle drops the queued byte
  wire pend_ok = pend_reg & ~(quiet_reg & ~slave_busy);
  wire commit = ~sleep & (pend_ok | m_done);
  wire [7:0] commit_data = pend_reg ? pend_data_reg : {msh_reg[6:0], mbit_reg};
  wire slave_load = enabled & ~is_master & ~tef_reg & (ld_tgl_reg == ak_s2_reg);
  wire mode_fault_flag_clr = ctrl1_wr & mode_fault_flag_armed_reg;
  wire tcf_clr = data_rd & tcf_armed_reg;
  wire tef_clr = data_wr & tef_armed_reg;
  // A clear in the cycle of a completion lets the new byte in
  wire tcf_load = commit & (~tcf_reg | tcf_clr);
  wire m_drive = enabled & is_master;
  wire s_drive = enabled & ~is_master & ~mode_fault_flag_reg & ~ss_s2_reg;

  // Control registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      c1_reg <= '0;
      c2_reg <= '0;
    end else begin
      if (ctrl1_wr) c1_reg <= ctrl1_wdata;
      if (ctrl2_wr) c2_reg <= ctrl2_wdata;
      if (fault_set) c1_reg.master_select <= 1'b0;
      if (fault_set && single) c2_reg.shared_pin_output_enable <= 1'b0;
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {ss_s1_reg, ss_s2_reg} <= 2'b11;
      {mi_s1_reg, mi_s2_reg, mo_s1_reg, mo_s2_reg} <= '0;
      {dt_s1_reg, dt_s2_reg, dt_s3_reg} <= '0;
      {ak_s1_reg, ak_s2_reg} <= 2'b00;
    end else begin
      ss_s1_reg <= ss_n_in;
      ss_s2_reg <= ss_s1_reg;
      mi_s1_reg <= miso_in;
      mi_s2_reg <= mi_s1_reg;
      mo_s1_reg <= mosi_in;
      mo_s2_reg <= mo_s1_reg;
      dt_s1_reg <= done_tgl_reg;
      dt_s2_reg <= dt_s1_reg;
      dt_s3_reg <= dt_s2_reg;
      ak_s1_reg <= ld_ack_reg;
      ak_s2_reg <= ak_s1_reg;
    end
  end

  // Flags; a hardware set wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_fault_flag_reg <= `MODE_FAULT_FLAG_RESET;
      tcf_reg <= `TCF_RESET;
      tef_reg <= `TEF_RESET;
      {mode_fault_flag_armed_reg, tcf_armed_reg, tef_armed_reg} <= '0;
    end else begin
      mode_fault_flag_reg <= fault_set | (mode_fault_flag_reg & ~mode_fault_flag_clr);
      tcf_reg <= tcf_load | (tcf_reg & ~tcf_clr);
      tef_reg <= m_start | slave_load | (tef_reg & ~tef_clr);
      if (status_rd) begin
        mode_fault_flag_armed_reg <= mode_fault_flag_reg;
        tcf_armed_reg <= tcf_reg;
        tef_armed_reg <= tef_reg;
      end else begin
        if (ctrl1_wr) mode_fault_flag_armed_reg <= 1'b0;
        if (data_rd) tcf_armed_reg <= 1'b0;
        if (data_wr) tef_armed_reg <= 1'b0;
      end
    end
  end

  // Data registers; a write not preceded by a status read is dropped
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_data_reg <= `DATA_RESET;
      rx_data_reg <= `DATA_RESET;
    end else begin
      if (tef_clr) tx_data_reg <= data_wdata;
      if (tcf_load) rx_data_reg <= commit_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_reg <= 1'b0;
      pend_data_reg <= '0;
    end else if (s_done) begin
      pend_reg <= 1'b1;
      pend_data_reg <= shold_reg;
    end else if (!sleep) begin
      pend_reg <= 1'b0;
    end
  end

  // note whether sleep began with the slave idle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_d_reg <= 1'b0;
      quiet_reg <= 1'b0;
    end else begin
      sleep_d_reg <= sleep;
      if (sleep && !sleep_d_reg) quiet_reg <= ~slave_busy;
      else if (!sleep) quiet_reg <= 1'b0;
    end
  end

  // Hands a private copy to the link domain, so a later write cannot alter a byte in flight
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ld_tgl_reg <= 1'b0;
      ld_data_reg <= `DATA_RESET;
    end else if (slave_load) begin
      ld_tgl_reg <= ~ld_tgl_reg;
      ld_data_reg <= tx_data_reg;
    end
  end

  // Master engine, mode 0, MSB first
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mstate_reg <= spi_bidir_pkg::M_IDLE;
      div_reg <= '0;
      edge_reg <= '0;
      sck_reg <= 1'b0;
      msh_reg <= '0;
      mbit_reg <= 1'b0;
    end else if (fault_set || !enabled || !is_master) begin
      mstate_reg <= spi_bidir_pkg::M_IDLE;
      sck_reg <= 1'b0;
      div_reg <= '0;
      edge_reg <= '0;
    end else if (m_start) begin
      mstate_reg <= spi_bidir_pkg::M_RUN;
      msh_reg <= tx_data_reg;
      div_reg <= '0;
      edge_reg <= '0;
    end else if (m_running && !sleep) begin
      div_reg <= half_tick ? 8'h00 : div_reg + 8'h01;
      if (half_tick) begin
        sck_reg <= ~sck_reg;
        edge_reg <= edge_reg + 4'h1;
        if (!edge_reg[0]) mbit_reg <= m_in;
        else msh_reg <= {msh_reg[6:0], mbit_reg};
        if (m_done) mstate_reg <= spi_bidir_pkg::M_IDLE;
      end
    end
  end

  // Slave link domain; a high select clears the bit count
  // shifting runs on the master clock regardless of power state
  always_ff @(posedge sck_in or posedge ss_n_in) begin
    if (ss_n_in) scnt_reg <= 3'h0;
    else scnt_reg <= scnt_reg + 3'h1;
  end

  always_ff @(posedge sck_in or posedge rst) begin
    if (rst) begin
      done_tgl_reg <= 1'b0;
      ld_ack_reg <= 1'b0;
      {ld_s1_reg, ld_s2_reg} <= 2'b00;
      shold_reg <= '0;
    end else begin
      ld_s1_reg <= ld_tgl_reg;
      ld_s2_reg <= ld_s1_reg;
      if (scnt_reg == 3'h0) ld_ack_reg <= ld_s2_reg;
      if (scnt_reg == 3'h7) begin
        shold_reg <= {srx_reg, slave_din};
        done_tgl_reg <= ~done_tgl_reg;
      end
    end
  end

  // Fresh data only if handed over before the frame, else echo last byte
  wire [7:0] next_byte = (ld_s2_reg != ld_ack_reg) ? ld_data_reg : shold_reg;
  always_ff @(posedge sck_in) begin
    srx_reg <= {srx_reg[5:0], slave_din};
    if (scnt_reg == 3'h0) stx_reg <= next_byte;
  end
  // Bit changes just after the sampling edge, giving the master a full period
  wire s_dout = (scnt_reg == 3'h0) ? next_byte[7] : stx_reg[3'h7 - scnt_reg];

  // Pin drive
  // SCK direction follows master select while the system is enabled
  assign sck_pin = '{out: sck_reg, oe: m_drive};
  wire m_mosi_oe = m_drive & (~single | c2_reg.shared_pin_output_enable);
  wire s_miso_oe = s_drive & (~single | c2_reg.shared_pin_output_enable);
  assign mosi_pin = '{out: msh_reg[7], oe: m_mosi_oe};
  assign miso_pin = '{out: s_dout, oe: s_miso_oe};
  assign ss_n_pin = '{out: ~m_running, oe: m_drive & ss_auto};

  // Status and interrupt
  assign ctrl1_q = c1_reg;
  assign ctrl2_q = c2_reg;
  assign status_q = '{mode_fault_flag: mode_fault_flag_reg, transfer_complete_flag: tcf_reg,
                      transmit_empty_flag: tef_reg};
  assign data_rdata = rx_data_reg;
  assign irq = enabled & (mode_fault_flag_reg | tcf_reg | tef_reg);

  // Checks
  fault_sets_flag_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      fault_set |=> mode_fault_flag_reg && !c1_reg.master_select)
    else $error("mode fault not raised");
  no_fault_off_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (!mode_fault_flag_reg && !c1_reg.mode_fault_detect_enable && !ctrl1_wr) |=> !mode_fault_flag_reg)
    else $error("mode fault without detection");
  fault_abort_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      fault_set |=> !m_running && !sck_pin.oe && !mosi_pin.oe && !miso_pin.oe)
    else $error("fault did not abort and release pins");
  fault_shared_oe_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (fault_set && single) |=> !c2_reg.shared_pin_output_enable)
    else $error("shared pin enable kept after fault");
  mode_fault_flag_clear_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (status_rd && mode_fault_flag_reg && !fault_set) ##1 (ctrl1_wr && !fault_set) |=> !mode_fault_flag_reg)
    else $error("mode fault not cleared");
  disabled_idle_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (!enabled && !ctrl1_wr) |=> !m_running && !irq)
    else $error("disabled core active");
  sleep_freeze_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (m_running && sleep && !fault_set && enabled && is_master) |=>
        $stable(edge_reg) && $stable(sck_reg))
    else $error("master advanced while asleep");
  defer_copy_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (sleep && !m_running) |=> $stable(rx_data_reg))
    else $error("data copied while asleep");
  irq_or_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      irq == (enabled && (mode_fault_flag_reg || tcf_reg || tef_reg)))
    else $error("interrupt mismatch");
  discard_full_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (commit && tcf_reg && !tcf_clr) |=> $stable(rx_data_reg))
    else $error("data overwritten while complete flag set");
  tef_hold_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (tef_reg && !data_wr) |=> tef_reg)
    else $error("empty flag dropped without service");
  auto_ss_a:
    assert property (@(posedge sys_clk) disable iff (rst)
      (ss_auto && !mode_fault_flag_reg && !ctrl1_wr) |=> !mode_fault_flag_reg)
    else $error("fault with select output on");
endmodule : spi_bidir_fault_power

// file: far_spi.sv
`timescale 1ns/10ps
module far_spi (
  // Device pin drives
  input wire spi_bidir_pkg::pin_drv_t sck_pin,
  input wire spi_bidir_pkg::pin_drv_t mosi_pin,
  input wire spi_bidir_pkg::pin_drv_t miso_pin,
  input wire spi_bidir_pkg::pin_drv_t ss_n_pin,
  // Resolved pin levels
  output logic sck_in,
  output logic mosi_in,
  output logic miso_in,
  output logic ss_n_in
);
  logic ss_n_drv = 1'b1;
  logic m_on = 1'b0;
  logic m_mosi = 1'b0;
  logic sck_drv = 1'b0;
  logic noise = 1'b0;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] s_rx = 8'h00;
  // Released lines wander so a stale level is never taken for data
  always #4 noise = ~noise;
  assign sck_in = sck_pin.oe ? sck_pin.out : sck_drv;
  assign mosi_in = mosi_pin.oe ? mosi_pin.out : (m_on ? m_mosi : noise);
  assign miso_in = miso_pin.oe ? miso_pin.out : (m_on ? noise : s_tx[7]);
  // A low select from us wins over the device's own select drive
  assign ss_n_in = ss_n_drv & (~ss_n_pin.oe | ss_n_pin.out);
  always @(posedge sck_pin.out) if (!m_on) s_rx <= {s_rx[6:0], mosi_in};
  always @(negedge sck_pin.out) if (!m_on) s_tx <= {s_tx[6:0], 1'b0};
  // Mode 0 master; clock stands low outside frames
  task automatic master_xfer(input logic [7:0] tx, output logic [7:0] rx);
    m_on = 1'b1;
    ss_n_drv = 1'b0;
    #25.3;
    for (int i = 7; i >= 0; i--) begin
      m_mosi = tx[i];
      #6 sck_drv = 1'b1;
      rx = {rx[6:0], miso_in};
      #6 sck_drv = 1'b0;
    end
    #12 ss_n_drv = 1'b1;
    m_on = 1'b0;
  endtask : master_xfer
endmodule : far_spi

// file: tb.sv
`timescale 1ns/10ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b0;
  logic cpu_wait = 1'b0, cpu_stop = 1'b0, ctrl1_wr = 1'b0, ctrl2_wr = 1'b0;
  logic status_rd = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
  logic [7:0] data_wdata = 8'h00, data_rdata, rx;
  spi_bidir_pkg::ctrl1_t ctrl1_wdata = '0, ctrl1_q;
  spi_bidir_pkg::ctrl2_t ctrl2_wdata = '0, ctrl2_q;
  spi_bidir_pkg::status_t status_q;
  spi_bidir_pkg::pin_drv_t sck_pin, mosi_pin, miso_pin, ss_n_pin;
  logic irq, sck_in, mosi_in, miso_in, ss_n_in;
  int mismatches = 0, num_checks = 0, cycles = 0;
  always #2 sys_clk = ~sys_clk;
  spi_bidir_fault_power spi_bidir_fault_power_i (.sys_clk(sys_clk), .rst(rst),
    .cpu_wait(cpu_wait), .cpu_stop(cpu_stop), .ctrl1_wr(ctrl1_wr), .ctrl1_wdata(ctrl1_wdata),
    .ctrl2_wr(ctrl2_wr), .ctrl2_wdata(ctrl2_wdata), .status_rd(status_rd), .data_rd(data_rd),
    .data_wr(data_wr), .data_wdata(data_wdata), .ctrl1_q(ctrl1_q), .ctrl2_q(ctrl2_q),
    .status_q(status_q), .data_rdata(data_rdata), .irq(irq), .sck_in(sck_in),
    .sck_pin(sck_pin), .mosi_in(mosi_in), .mosi_pin(mosi_pin), .miso_in(miso_in),
    .miso_pin(miso_pin), .ss_n_in(ss_n_in), .ss_n_pin(ss_n_pin));
  far_spi far_spi_i (.sck_pin(sck_pin), .mosi_pin(mosi_pin), .miso_pin(miso_pin),
    .ss_n_pin(ss_n_pin), .sck_in(sck_in), .mosi_in(mosi_in), .miso_in(miso_in),
    .ss_n_in(ss_n_in));
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  // Kinds: 0 status read, 1 data read, 2 data write, 3 ctrl1 write, 4 ctrl2 write
  task automatic pulse(input int k, input logic [7:0] d);
    @(negedge sys_clk);
    data_wdata = d;
    ctrl1_wdata = spi_bidir_pkg::ctrl1_t'(d[3:0]);
    ctrl2_wdata = spi_bidir_pkg::ctrl2_t'(d[2:0]);
    case (k)
      0: status_rd = 1'b1;
      1: data_rd = 1'b1;
      2: data_wr = 1'b1;
      3: ctrl1_wr = 1'b1;
      default: ctrl2_wr = 1'b1;
    endcase
    @(negedge sys_clk);
    {status_rd, data_rd, data_wr, ctrl1_wr, ctrl2_wr} = 5'h00;
  endtask : pulse
  task automatic mstart(input logic [7:0] d, input logic [7:0] reply);
    far_spi_i.s_tx = reply;
    pulse(0, 8'h00);
    pulse(2, d);
  endtask : mstart
  task automatic tc_clear;
    pulse(0, 8'h00);
    pulse(1, 8'h00);
  endtask : tc_clear
  task automatic wait_tc;
    int n;
    n = 0;
    while (status_q.transfer_complete_flag !== 1'b1 && n < 500) begin
      cyc(1);
      n++;
    end
    chk("complete", 8'h01, 8'(status_q.transfer_complete_flag));
  endtask : wait_tc
  task automatic fault_is(input logic exp);
    chk("mode fault", 8'(exp), 8'(status_q.mode_fault_flag));
  endtask : fault_is
  task automatic ss_low;
    far_spi_i.ss_n_drv = 1'b0;
    cyc(6);
  endtask : ss_low
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    // Raised after time zero so the link-domain reset sees an edge
    #1 rst = 1'b1;
    cyc(5);
    rst = 1'b0;
    cyc(1);
    chk("status", 8'h01, 8'(status_q));
    chk("rdata", 8'h00, data_rdata);
    chk("irq", 8'h00, 8'(irq));
    chk("oe", 8'h00, {sck_pin.oe, mosi_pin.oe, miso_pin.oe, ss_n_pin.oe});
    pulse(3, 8'h04);
    mstart(8'h11, 8'h22);
    cyc(100);
    chk("off oe", 8'h00, {7'h00, sck_pin.oe | status_q.transfer_complete_flag});
    pulse(3, 8'h0C);
    chk("sck oe", 8'h01, 8'(sck_pin.oe));
    wait_tc();
    chk("rdata", 8'h22, data_rdata);
    chk("far rx", 8'h11, far_spi_i.s_rx);
    chk("irq tef", 8'h03, {6'h00, irq, status_q.transmit_empty_flag});
    mstart(8'h33, 8'h44);
    cyc(100);
    chk("kept", 8'h22, data_rdata);
    tc_clear();
    chk("tc", 8'h00, 8'(status_q.transfer_complete_flag));
    for (int m = 0; m < 3; m++) begin
      pulse(4, m == 1 ? 8'h01 : 8'h00);
      mstart(8'h50 + 8'(m), 8'hA0 + 8'(m));
      cyc(20);
      if (m == 0) cpu_stop = 1'b1;
      else cpu_wait = 1'b1;
      cyc(200);
      chk("asleep tc", 8'(m == 2), 8'(status_q.transfer_complete_flag));
      cpu_stop = 1'b0;
      cpu_wait = 1'b0;
      wait_tc();
      chk("woke rx", 8'hA0 + 8'(m), data_rdata);
      chk("far rx", 8'h50 + 8'(m), far_spi_i.s_rx);
      tc_clear();
    end
    pulse(4, 8'h00);
    pulse(3, 8'h0D);
    ss_low();
    fault_is(1'b1);
    chk("fault master_select", 8'h00, {4'h0, ctrl1_q.master_select, sck_pin.oe, mosi_pin.oe,
      miso_pin.oe});
    chk("fault irq", 8'h01, 8'(irq));
    far_spi_i.ss_n_drv = 1'b1;
    pulse(3, 8'h0C);
    fault_is(1'b1);
    pulse(0, 8'h00);
    pulse(3, 8'h0C);
    fault_is(1'b0);
    for (int i = 0; i < 3; i++) begin
      pulse(3, i == 0 ? 8'h0C : (i == 1 ? 8'h0F : 8'h09));
      ss_low();
      fault_is(1'b0);
      far_spi_i.ss_n_drv = 1'b1;
    end
    pulse(4, 8'h04);
    pulse(3, 8'h0D);
    chk("sw oe", 8'h00, {6'h00, mosi_pin.oe, miso_pin.oe});
    pulse(4, 8'h06);
    chk("sw mosi", 8'h01, 8'(mosi_pin.oe));
    chk("sw miso", 8'h00, 8'(miso_pin.oe));
    ss_low();
    chk("sw dir", 8'h00, 8'(ctrl2_q.shared_pin_output_enable));
    far_spi_i.ss_n_drv = 1'b1;
    pulse(0, 8'h00);
    pulse(4, 8'h00);
    pulse(3, 8'h08);
    mstart(8'h5A, 8'h00);
    far_spi_i.master_xfer(8'hC3, rx);
    wait_tc();
    chk("slave rx", 8'hC3, data_rdata);
    chk("slave sck", 8'h00, 8'(sck_pin.oe));
    far_spi_i.master_xfer(8'h96, rx);
    chk("slave tx", 8'h5A, rx);
    cyc(10);
    chk("dropped", 8'hC3, data_rdata);
    tc_clear();
    pulse(4, 8'h01);
    cpu_wait = 1'b1;
    far_spi_i.master_xfer(8'h0F, rx);
    chk("echo", 8'h96, rx);
    cyc(20);
    chk("held", 8'hC3, data_rdata | {7'h00, status_q.transfer_complete_flag});
    cpu_wait = 1'b0;
    cyc(20);
    chk("idle wait", 8'hC3, data_rdata | {7'h00, status_q.transfer_complete_flag});
    // Wait begins mid-frame, so the byte must land on exit
    fork
      far_spi_i.master_xfer(8'h3C, rx);
      begin
        cyc(4);
        cpu_wait = 1'b1;
      end
    join
    cyc(20);
    chk("held", 8'hC3, data_rdata | {7'h00, status_q.transfer_complete_flag});
    cpu_wait = 1'b0;
    wait_tc();
    chk("late rx", 8'h3C, data_rdata);
    chk("echo", 8'h0F, rx);
    close_out();
  end
endmodule : tb
